//--- hdl/fault_mgr_pkg.sv
package fault_mgr_pkg;

	// ---------------------------------------------------------------
	// register map (word offsets as byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
	localparam logic [3:0] IRQ_MASK_OFS = 4'hc;

	// control field positions
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_ALARM_SEL_BIT = 1;
	localparam int CTRL_OVERVOLTAGE_PROTECT_ENABLE_BIT = 2;
	localparam int CTRL_OCP_LO_BIT = 4;

	// reset values
	localparam logic [1:0] OCP_SEL_RST = 2'h0;
	localparam logic IRQ_MASK_RST = 1'b0;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int REPORT_MS = 200;
	localparam int REPORT_CYC = REPORT_MS * (CLK_HZ / 1000);
	localparam int RETRY_MS = 5;
	localparam int RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);

	// overcurrent response codes
	typedef enum logic [1:0] {
		OCP_LATCH = 2'h0,
		OCP_RETRY = 2'h1,
		OCP_REPORT = 2'h2,
		OCP_IGNORE = 2'h3
	} ocp_sel_t;

	// raw fault conditions
	typedef struct packed {
		logic supply_uv;
		logic pump_uv;
		logic overvolt;
		logic phase_oc;
		logic reg_oc;
	} fault_in_t;

	// reported flags
	typedef struct packed {
		logic pump_uv;
		logic overvolt;
		logic phase_oc;
	} fault_flags_t;

endpackage

//--- hdl/motor_driver_fault_manager.sv
// How it works
// - actionable fault pulls fault indicator low
// - alarm select set: actionable fault raises alarm
// - report-only goes to indicator or alarm
// - priority latched, retry, report
// - persisting overcurrent restarts the retry interval
// - latched fault holds Hi-Z until clear write
// - retry fault recovers after interval, others once condition gone
// - report shows within 200 ms of Hi-Z
// - latched fault clears within 200 ms of clear
// - supply undervoltage: Hi-Z, logic off, auto resume
// - pump undervoltage: Hi-Z, report, auto recover
// - overvoltage acts only when protection enabled
// - overcurrent response by select code
// - regulator overcurrent: Hi-Z, logic off, silent
//
// Register access over Avalon-MM and the address map are this design's own decisions.
module motor_driver_fault_manager
	import fault_mgr_pkg::*;
#(
	parameter int REPORT_CYCLES = REPORT_CYC,
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	// fault conditions
	input wire fault_mgr_pkg::fault_in_t fault_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// pins and power stage
	output logic fault_indicator_low_o,
	output logic fault_indicator_low_oe_o,
	output logic alarm_o,
	output logic stage_hiz_o,
	output logic logic_disable_o,
	output logic irq_o
);
	import fault_mgr_pkg::*;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic fault_clear_bit_r;
	logic alarm_sel_r;
	logic overvoltage_protect_enable_r;
	ocp_sel_t overcurrent_response_select_r;
	fault_flags_t irq_stat_r, irq_mask_r;
	fault_flags_t flags_r;
	logic ack_r;
	logic latched_r;
	logic retry_active_r;
	logic [31:0] retry_cnt_r;
	fault_flags_t flags_old_r;
	fault_flags_t flag_rise;
	logic [31:0] clr_cnt_r;
	logic clr_pend_r;
	logic act_seen_r;

	logic pump_act, ovp_act, oc_latch, oc_retry, oc_report;
	logic actionable, report_only, auto_hiz, reported;
	logic acc, wr, rd;

	always_comb begin
		pump_act = fault_i.pump_uv;
		ovp_act = fault_i.overvolt & overvoltage_protect_enable_r;
		oc_latch = fault_i.phase_oc &&
			overcurrent_response_select_r == OCP_LATCH;
		oc_retry = fault_i.phase_oc &&
			overcurrent_response_select_r == OCP_RETRY;
		oc_report = fault_i.phase_oc &&
			overcurrent_response_select_r == OCP_REPORT;
		auto_hiz = fault_i.supply_uv | fault_i.reg_oc |
			pump_act | ovp_act;
		actionable = latched_r | retry_active_r | pump_act | ovp_act;
		report_only = oc_report;
		reported = act_seen_r;
	end

	// ---------------------------------------------------------------
	// bus slave: one wait cycle, then answer
	// ---------------------------------------------------------------
	assign acc = (avs_read_i | avs_write_i) & ~ack_r;
	assign wr = avs_write_i & ack_r;
	assign rd = avs_read_i & ack_r;

	// waitrequest kept as its own flop so the pin has no logic path
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ack_r <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else if (en_i) begin
			ack_r <= acc;
			avs_waitrequest_o <= ~acc;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			alarm_sel_r <= 1'b0;
			overvoltage_protect_enable_r <= 1'b0;
			overcurrent_response_select_r <= ocp_sel_t'(OCP_SEL_RST);
			irq_mask_r <= '{default: IRQ_MASK_RST};
		end else if (en_i && wr) begin
			if (avs_address_i == CTRL_OFS) begin
				alarm_sel_r <= avs_writedata_i[CTRL_ALARM_SEL_BIT];
				overvoltage_protect_enable_r <=
					avs_writedata_i[CTRL_OVERVOLTAGE_PROTECT_ENABLE_BIT];
				overcurrent_response_select_r <= ocp_sel_t'(
					avs_writedata_i[CTRL_OCP_LO_BIT +: 2]);
			end else if (avs_address_i == IRQ_MASK_OFS)
				irq_mask_r <= avs_writedata_i[2:0];
		end
	end

	// self-clearing clear request
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			fault_clear_bit_r <= 1'b0;
		else if (en_i) begin
			if (wr && avs_address_i == CTRL_OFS)
				fault_clear_bit_r <= avs_writedata_i[CTRL_CLR_BIT];
			else
				fault_clear_bit_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			avs_readdata_o <= 32'h0;
		else if (en_i) begin
			avs_readdata_o <= 32'h0;
			if (acc && avs_read_i) begin
				case (avs_address_i)
				CTRL_OFS: avs_readdata_o <= {26'h0,
					overcurrent_response_select_r, 1'b0,
					overvoltage_protect_enable_r, alarm_sel_r, 1'b0};
				STAT_OFS: avs_readdata_o <= {26'h0, latched_r,
					retry_active_r, 1'b0, flags_r};
				IRQ_STAT_OFS: avs_readdata_o <= {29'h0, irq_stat_r};
				IRQ_MASK_OFS: avs_readdata_o <= {29'h0, irq_mask_r};
				default: avs_readdata_o <= 32'h0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// latched and retry faults
	// ---------------------------------------------------------------
	// clear is held pending; a latched fault drops only once the
	// overcurrent is gone, within the allowed clear delay
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			clr_pend_r <= 1'b0;
			clr_cnt_r <= 32'h0;
		end else if (en_i) begin
			if (fault_clear_bit_r) begin
				clr_pend_r <= 1'b1;
				clr_cnt_r <= 32'h0;
			end else if (clr_pend_r) begin
				clr_cnt_r <= clr_cnt_r + 32'h1;
				if (!latched_r || clr_cnt_r >= REPORT_CYCLES - 1)
					clr_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			latched_r <= 1'b0;
		else if (en_i) begin
			if (oc_latch)
				latched_r <= 1'b1;
			else if (clr_pend_r)
				latched_r <= 1'b0;
		end
	end

	// retry timer restarts while the overcurrent retry cause persists, so
	// the interval always runs from the last cycle of that cause
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			retry_active_r <= 1'b0;
			retry_cnt_r <= 32'h0;
		end else if (en_i) begin
			if (oc_retry) begin
				retry_active_r <= 1'b1;
				retry_cnt_r <= 32'h0;
			end else if (retry_active_r) begin
				if (retry_cnt_r >= RETRY_CYCLES - 1)
					retry_active_r <= 1'b0;
				else
					retry_cnt_r <= retry_cnt_r + 32'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// report delay after Hi-Z (fixed one cycle, well inside bound)
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			act_seen_r <= 1'b0;
		else if (en_i)
			act_seen_r <= actionable;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			stage_hiz_o <= 1'b1;
			logic_disable_o <= 1'b0;
			fault_indicator_low_o <= 1'b0;
			fault_indicator_low_oe_o <= 1'b1;
			alarm_o <= 1'b0;
		end else if (en_i) begin
			// latched outranks retry, retry outranks report
			stage_hiz_o <= latched_r | retry_active_r |
				auto_hiz;
			logic_disable_o <= fault_i.supply_uv |
				fault_i.reg_oc;
			fault_indicator_low_o <= 1'b0;
			// oe low drives pin low; released otherwise (pull-up)
			fault_indicator_low_oe_o <= ~(reported |
				(report_only & ~alarm_sel_r));
			alarm_o <= alarm_sel_r &
				(reported | report_only);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			flags_r <= '0;
		else if (en_i) begin
			flags_r.pump_uv <= pump_act;
			flags_r.overvolt <= ovp_act;
			flags_r.phase_oc <= latched_r | retry_active_r |
				oc_report;
		end
	end

	// sticky events are flag rises, so a read clear holds while a
	// fault persists; a new event wins over a read clear
	assign flag_rise = flags_r & ~flags_old_r;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			flags_old_r <= '0;
			irq_stat_r <= '0;
		end else if (en_i) begin
			flags_old_r <= flags_r;
			if (rd && avs_address_i == IRQ_STAT_OFS)
				irq_stat_r <= flag_rise;
			else
				irq_stat_r <= irq_stat_r | flag_rise;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			irq_o <= 1'b0;
		else if (en_i)
			irq_o <= |(irq_stat_r & irq_mask_r);
	end

endmodule

//--- verification/fault_mgr_sva.sv
module fault_mgr_chk
	import fault_mgr_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire fault_mgr_pkg::fault_in_t fault_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic fault_indicator_low_o,
	input wire logic fault_indicator_low_oe_o,
	input wire logic alarm_o,
	input wire logic stage_hiz_o,
	input wire logic logic_disable_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	// en_i low freezes state, so nothing is judged then
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i || !en_i);
	chk_pin_value: assert property (
		fault_indicator_low_o == 1'b0) else $error("pin value not low");
	chk_uv_off: assert property ($rose(fault_i.supply_uv) |->
		##[1:2] stage_hiz_o && logic_disable_o) else $error("uv not off");
	chk_regoc_off: assert property ($rose(fault_i.reg_oc) |->
		##[1:2] stage_hiz_o && logic_disable_o) else $error("oc not off");
	chk_reg_silent: assert property (fault_i == 5'h01 &&
		fault_indicator_low_oe_o |=> fault_indicator_low_oe_o)
		else $error("regulator fault reported");
	chk_pump_hiz: assert property ((fault_i.pump_uv &&
		!fault_i.supply_uv && !fault_i.reg_oc) [*3] |->
		stage_hiz_o && !logic_disable_o) else $error("pump not hiz");
	chk_pump_pin: assert property (fault_i.pump_uv [*3] |->
		!fault_indicator_low_oe_o) else $error("pump not shown");
	chk_wait_one: assert property (
		$rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
		else $error("bus answer late");
	chk_wait_short: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("bus answer too long");
	cover property (stage_hiz_o && !fault_indicator_low_oe_o);
	cover property (alarm_o && fault_indicator_low_oe_o);
	cover property (logic_disable_o);
endmodule

//--- verification/host_pin_model.sv
module host_pin_model (
	// pin drive from the device
	input wire logic drv_i,
	input wire logic oe_i,
	// level the host sees
	output wire logic pin_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// external pull-up holds the line high when released
	assign pin_n_o = oe_i ? 1'b1 : drv_i;
endmodule

//--- verification/motor_driver_fault_manager_test.sv
module motor_driver_fault_manager_test;
	timeunit 1ns;
	timeprecision 1ns;
	import fault_mgr_pkg::*;
	logic clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd_d;
	fault_in_t fault_i = '0;
	logic avs_waitrequest_o, fault_indicator_low_o, fault_indicator_low_oe_o;
	logic alarm_o, stage_hiz_o, logic_disable_o, irq_o;
	wire pin_n;
	int err_count = 0, tests_run = 0;
	// short counts keep the run brief
	motor_driver_fault_manager #(.REPORT_CYCLES(20), .RETRY_CYCLES(20)) uut (
		.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .fault_i(fault_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.fault_indicator_low_o(fault_indicator_low_o),
		.fault_indicator_low_oe_o(fault_indicator_low_oe_o),
		.alarm_o(alarm_o), .stage_hiz_o(stage_hiz_o),
		.logic_disable_o(logic_disable_o), .irq_o(irq_o));
	host_pin_model host (.drv_i(fault_indicator_low_o),
		.oe_i(fault_indicator_low_oe_o), .pin_n_o(pin_n));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// -------------------------------------------------
	// tasks
	// -------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic bad(input string m);
		err_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) bad("register value mismatch");
	endtask
	task automatic pins(input logic h, input logic p, input logic a);
		tests_run++;
		if ({stage_hiz_o, pin_n, alarm_o} !== {h, p, a}) bad("pin mismatch");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic flt(input fault_in_t f);
		@(posedge clk_i);
		fault_i <= f;
	endtask
	// holds the request until waitrequest is seen low
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50) begin
			bad("bus timeout");
			tally_and_finish();
		end else begin
			rd_d = avs_readdata_o;
			@(posedge clk_i);
			avs_read_i <= 1'b0;
			avs_write_i <= 1'b0;
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		cmp(rd_d, e);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	// -------------------------------------------------
	// sequence
	// -------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		cyc(2);
		pins(1'b0, 1'b1, 1'b0);
		rd(CTRL_OFS, 32'h0);
		rd(IRQ_MASK_OFS, 32'h0);
		rd(4'h1, 32'h0);
		done("reset");
		acc(1'b1, IRQ_MASK_OFS, 32'h7);
		flt(5'h02);
		cyc(3);
		pins(1'b1, 1'b0, 1'b0);
		rd(STAT_OFS, 32'h21);
		flt(5'h00);
		cyc(30);
		pins(1'b1, 1'b0, 1'b0);
		cmp({31'h0, irq_o}, 32'h1);
		rd(IRQ_STAT_OFS, 32'h1);
		cyc(2);
		cmp({31'h0, irq_o}, 32'h0);
		acc(1'b1, CTRL_OFS, 32'h1);
		cyc(5);
		pins(1'b0, 1'b1, 1'b0);
		rd(CTRL_OFS, 32'h0);
		done("latch");
		acc(1'b1, CTRL_OFS, 32'h12);
		flt(5'h02);
		cyc(3);
		pins(1'b1, 1'b0, 1'b1);
		flt(5'h00);
		cyc(10);
		pins(1'b1, 1'b0, 1'b1);
		cyc(20);
		pins(1'b0, 1'b1, 1'b0);
		done("retry");
		acc(1'b1, CTRL_OFS, 32'h22);
		flt(5'h02);
		cyc(3);
		pins(1'b0, 1'b1, 1'b1);
		acc(1'b1, CTRL_OFS, 32'h20);
		cyc(3);
		pins(1'b0, 1'b0, 1'b0);
		acc(1'b1, CTRL_OFS, 32'h30);
		cyc(3);
		pins(1'b0, 1'b1, 1'b0);
		flt(5'h04);
		cyc(3);
		pins(1'b0, 1'b1, 1'b0);
		acc(1'b1, CTRL_OFS, 32'h34);
		cyc(3);
		pins(1'b1, 1'b0, 1'b0);
		flt(5'h00);
		cyc(3);
		pins(1'b0, 1'b1, 1'b0);
		done("report");
		flt(5'h10);
		cyc(3);
		cmp({30'h0, stage_hiz_o, logic_disable_o}, 32'h3);
		flt(5'h01);
		cyc(3);
		pins(1'b1, 1'b1, 1'b0);
		flt(5'h00);
		cyc(3);
		cmp({30'h0, stage_hiz_o, logic_disable_o}, 32'h0);
		acc(1'b1, CTRL_OFS, 32'h0);
		flt(5'h0a);
		cyc(3);
		pins(1'b1, 1'b0, 1'b0);
		flt(5'h00);
		cyc(5);
		pins(1'b1, 1'b0, 1'b0);
		acc(1'b1, CTRL_OFS, 32'h1);
		cyc(5);
		pins(1'b0, 1'b1, 1'b0);
		done("mixed");
		@(posedge clk_i);
		en_i <= 1'b0;
		fault_i <= 5'h10;
		cyc(3);
		cmp({30'h0, stage_hiz_o, logic_disable_o}, 32'h0);
		@(posedge clk_i);
		en_i <= 1'b1;
		cyc(3);
		cmp({30'h0, stage_hiz_o, logic_disable_o}, 32'h3);
		flt(5'h00);
		cyc(3);
		pins(1'b0, 1'b1, 1'b0);
		done("freeze");
		tally_and_finish();
	end
endmodule
bind motor_driver_fault_manager fault_mgr_chk chk (.clk_i(clk_i),
	.nrst_i(nrst_i), .en_i(en_i), .fault_i(fault_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.fault_indicator_low_o(fault_indicator_low_o),
	.fault_indicator_low_oe_o(fault_indicator_low_oe_o),
	.alarm_o(alarm_o), .stage_hiz_o(stage_hiz_o),
	.logic_disable_o(logic_disable_o));
